// *** cmsir_regs.sv ***
// Purpose: status, interrupt and cell control registers of a cell monitor
// Assumes: conversion engine, timer and serial checker report events as pulses
// Notes: axi4-lite slave, one write and one read outstanding at a time
`timescale 1ns/1ps
module cmsir_regs
   import cmsir_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic conversion_finished,
   input wire logic slow_timer_elapsed,
   input wire logic bad_frame_length,
   input wire logic checksum_fault,
   input wire logic factory_test_active,
   input wire logic cell_sample_valid,
   input wire logic [2:0] cell_sample_index,
   input wire logic [11:0] cell_sample_value,
   output logic conversion_start,
   output logic conversion_abort,
   output logic slow_timer_restart,
   output logic slow_timer_enable,
   output logic [11:0] low_cell_threshold,
   output logic [5:0] cell_balance_enable,
   output logic irq
);
   // ==========================================================
   // decode
   function automatic logic [7:0] reg_index(input logic [31:0] addr);
      reg_index = addr[9:2];
   endfunction

   function automatic logic is_mapped(input logic [7:0] idx);
      case (idx)
         CMSIR_IDX_CONTROL, CMSIR_IDX_OPERATION, CMSIR_IDX_PROGRESS, CMSIR_IDX_SOFT_RESET,
         CMSIR_IDX_MASK, CMSIR_IDX_FLAGS, CMSIR_IDX_CELL_LOW, CMSIR_IDX_BALANCE,
         CMSIR_IDX_THRESHOLD: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   logic [31:0] aw_addr_reg;
   logic aw_have_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic w_have_reg;
   logic [7:0] widx;
   logic [7:0] ridx;
   logic wr_fire;
   logic rd_fire;
   logic wr_lane0;
   logic [1:0] progress_reg;
   logic [4:0] flags_reg;
   logic powerup_reg;
   logic test_reg;
   logic [4:0] mask_reg;
   logic [5:0] cell_low_reg;
   logic [7:0] control_reg;
   logic request_reg;
   logic ack_pending_reg;
   cmsir_conv_t conv_reg;
   logic [4:0] event_vec;
   logic low_event;
   logic rd_flags;
   logic rd_progress;
   logic wr_request;
   logic wr_idle;

   // ==========================================================
   // write channel: address and data taken in either order
   assign widx = reg_index(aw_addr_reg);
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign wr_lane0 = w_strb_reg[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 32'h0000_0000;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CMSIR_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(widx) ? CMSIR_RESP_OKAY : CMSIR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read channel
   assign ridx = reg_index(s_axi_araddr);
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_flags = rd_fire && (ridx == CMSIR_IDX_FLAGS);
   assign rd_progress = rd_fire && (ridx == CMSIR_IDX_PROGRESS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CMSIR_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(ridx) ? CMSIR_RESP_OKAY : CMSIR_RESP_SLVERR;
            case (ridx)
               CMSIR_IDX_CONTROL: s_axi_rdata <= {24'h000000, control_reg};
               CMSIR_IDX_OPERATION: s_axi_rdata <= {31'h0, request_reg};
               CMSIR_IDX_PROGRESS: s_axi_rdata <= {30'h0, progress_reg};
               CMSIR_IDX_MASK: s_axi_rdata <= {27'h0, mask_reg};
               CMSIR_IDX_FLAGS: s_axi_rdata <= {25'h0, test_reg, powerup_reg, flags_reg};
               CMSIR_IDX_CELL_LOW: s_axi_rdata <= {26'h0, cell_low_reg};
               CMSIR_IDX_BALANCE: s_axi_rdata <= {26'h0, cell_balance_enable};
               CMSIR_IDX_THRESHOLD: s_axi_rdata <= {20'h00000, low_cell_threshold};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_reg <= CMSIR_RST_CONTROL;
         mask_reg <= CMSIR_RST_ZERO[4:0];
         cell_balance_enable <= CMSIR_RST_ZERO[5:0];
         low_cell_threshold <= CMSIR_RST_THRESHOLD;
         slow_timer_enable <= CMSIR_RST_CONTROL[CMSIR_BIT_TIMER_EN];
         slow_timer_restart <= 1'b0;
      end else begin
         slow_timer_restart <= 1'b0;
         slow_timer_enable <= control_reg[CMSIR_BIT_TIMER_EN];
         if (wr_fire && wr_lane0) begin
            case (widx)
               CMSIR_IDX_CONTROL: control_reg <= w_data_reg[7:0];
               CMSIR_IDX_MASK: mask_reg <= w_data_reg[4:0];
               // all six enables stored independently
               CMSIR_IDX_BALANCE: cell_balance_enable <= w_data_reg[5:0];
               CMSIR_IDX_SOFT_RESET:
                  slow_timer_restart <= w_data_reg[CMSIR_BIT_RESTART]
                     && control_reg[CMSIR_BIT_TIMER_EN];
               default: ;
            endcase
            if (widx == CMSIR_IDX_THRESHOLD && w_strb_reg[1]) begin
               low_cell_threshold <= w_data_reg[11:0];
            end
         end
      end
   end

   // ==========================================================
   // conversion request and progress
   assign wr_request = wr_fire && wr_lane0 && (widx == CMSIR_IDX_OPERATION);
   assign wr_idle = wr_request && !w_data_reg[CMSIR_BIT_REQUEST];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_reg <= CMSIR_S_IDLE;
         request_reg <= 1'b0;
         progress_reg <= CMSIR_PROG_IDLE;
         ack_pending_reg <= 1'b0;
         conversion_start <= 1'b0;
         conversion_abort <= 1'b0;
      end else begin
         conversion_start <= 1'b0;
         conversion_abort <= 1'b0;
         case (conv_reg)
            CMSIR_S_IDLE: begin
               if (rd_progress && progress_reg != CMSIR_PROG_RUN) begin
                  progress_reg <= CMSIR_PROG_IDLE;
               end
               if (ack_pending_reg && rd_flags) begin
                  request_reg <= 1'b0;
                  ack_pending_reg <= 1'b0;
               end
               // no progress read needed before a new start
               if (wr_request && w_data_reg[CMSIR_BIT_REQUEST]) begin
                  request_reg <= 1'b1;
                  ack_pending_reg <= 1'b0;
                  progress_reg <= CMSIR_PROG_RUN;
                  conversion_start <= 1'b1;
                  conv_reg <= CMSIR_S_RUN;
               end else if (wr_idle) begin
                  request_reg <= 1'b0;
               end
            end
            CMSIR_S_RUN: begin
               // reads do not touch progress here
               if (wr_idle) begin
                  request_reg <= 1'b0;
                  progress_reg <= CMSIR_PROG_CANCEL;
                  conversion_abort <= 1'b1;
                  conv_reg <= CMSIR_S_IDLE;
               end else if (conversion_finished) begin
                  progress_reg <= CMSIR_PROG_DONE;
                  ack_pending_reg <= 1'b1;
                  conv_reg <= CMSIR_S_IDLE;
               end
            end
            default: conv_reg <= CMSIR_S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // event flags, set beats clear
   assign low_event = cell_sample_valid && (cell_sample_index < 3'd6)
      && (cell_sample_value < low_cell_threshold);
   assign event_vec = {checksum_fault, low_event, bad_frame_length, slow_timer_elapsed,
      conversion_finished && conv_reg == CMSIR_S_RUN && !wr_idle};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_flag
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               flags_reg[gi] <= CMSIR_RST_FLAGS[gi];
            end else if (event_vec[gi]) begin
               flags_reg[gi] <= 1'b1;
            end else if (rd_flags) begin
               flags_reg[gi] <= 1'b0;
            end
         end
      end
      for (gi = 0; gi < 6; gi++) begin : g_cell
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cell_low_reg[gi] <= CMSIR_RST_ZERO[gi];
            end else if (low_event && cell_sample_index == 3'(gi)) begin
               cell_low_reg[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         powerup_reg <= CMSIR_RST_FLAGS[CMSIR_BIT_POWERUP];
         test_reg <= CMSIR_RST_FLAGS[CMSIR_BIT_TEST];
      end else begin
         test_reg <= factory_test_active;
         if (rd_flags) begin
            powerup_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // interrupt level; powerup and test bits left out
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags_reg & ~mask_reg);
      end
   end

   // ==========================================================
   // checks
   property p_irq_level;
      @(posedge aclk) disable iff (!aresetn)
      |(flags_reg & ~mask_reg) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq missing");

   property p_irq_masked;
      @(posedge aclk) disable iff (!aresetn)
      (flags_reg & ~mask_reg) == 5'h00 |=> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq w/o source");

   property p_read_clears;
      @(posedge aclk) disable iff (!aresetn)
      rd_flags && event_vec == 5'h00 |=> flags_reg == 5'h00 && !powerup_reg;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flags kept");

   property p_set_wins;
      @(posedge aclk) disable iff (!aresetn)
      rd_flags && event_vec[CMSIR_BIT_TIMER] |=> flags_reg[CMSIR_BIT_TIMER];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");

   sequence s_clear_read;
      rd_flags && event_vec == 5'h00;
   endsequence
   property p_irq_release;
      @(posedge aclk) disable iff (!aresetn)
      s_clear_read ##1 1'b1 |=> !irq;
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("irq held");

   property p_abort;
      @(posedge aclk) disable iff (!aresetn)
      conv_reg == CMSIR_S_RUN && wr_idle |=> progress_reg == CMSIR_PROG_CANCEL;
   endproperty
   a_abort: assert property (p_abort) else $error("abort missed");

   property p_run_stable;
      @(posedge aclk) disable iff (!aresetn)
      conv_reg == CMSIR_S_RUN && !wr_idle && !conversion_finished |=> progress_reg == CMSIR_PROG_RUN;
   endproperty
   a_run_stable: assert property (p_run_stable) else $error("progress moved");

   property p_progress_clear;
      @(posedge aclk) disable iff (!aresetn)
      rd_progress && conv_reg == CMSIR_S_IDLE && !wr_request |=> progress_reg == CMSIR_PROG_IDLE;
   endproperty
   a_progress_clear: assert property (p_progress_clear) else $error("no clear");

   property p_restart;
      @(posedge aclk) disable iff (!aresetn)
      slow_timer_restart |-> $past(control_reg[CMSIR_BIT_TIMER_EN]);
   endproperty
   a_restart: assert property (p_restart) else $error("restart w/o enable");
endmodule

// *** cmsir_pkg.sv ***
// Purpose: constants for the cell monitor status and interrupt register bank
// Assumes: 32-bit axi4-lite data, one aligned word per register
// Notes: offsets are register indices, byte address is index times four
package cmsir_pkg;
   // ==========================================================
   // register indices
   localparam logic [7:0] CMSIR_IDX_OPERATION = 8'h02;
   localparam logic [7:0] CMSIR_IDX_PROGRESS = 8'h03;
   localparam logic [7:0] CMSIR_IDX_SOFT_RESET = 8'h04;
   localparam logic [7:0] CMSIR_IDX_MASK = 8'h05;
   localparam logic [7:0] CMSIR_IDX_FLAGS = 8'h06;
   localparam logic [7:0] CMSIR_IDX_CELL_LOW = 8'h08;
   localparam logic [7:0] CMSIR_IDX_BALANCE = 8'h09;
   localparam logic [7:0] CMSIR_IDX_CONTROL = 8'h01;
   localparam logic [7:0] CMSIR_IDX_THRESHOLD = 8'h10;
   // ==========================================================
   // progress encodings
   localparam logic [1:0] CMSIR_PROG_IDLE = 2'h0;
   localparam logic [1:0] CMSIR_PROG_RUN = 2'h1;
   localparam logic [1:0] CMSIR_PROG_DONE = 2'h2;
   localparam logic [1:0] CMSIR_PROG_CANCEL = 2'h3;
   // ==========================================================
   // field positions
   localparam int CMSIR_BIT_DONE = 0;
   localparam int CMSIR_BIT_TIMER = 1;
   localparam int CMSIR_BIT_LENGTH = 2;
   localparam int CMSIR_BIT_LOW = 3;
   localparam int CMSIR_BIT_CHECKSUM = 4;
   localparam int CMSIR_BIT_POWERUP = 5;
   localparam int CMSIR_BIT_TEST = 6;
   localparam int CMSIR_BIT_RESTART = 1;
   localparam int CMSIR_BIT_TIMER_EN = 3;
   localparam int CMSIR_BIT_REQUEST = 0;
   // ==========================================================
   // reset values
   localparam logic [7:0] CMSIR_RST_FLAGS = 8'h20;
   localparam logic [7:0] CMSIR_RST_ZERO = 8'h00;
   localparam logic [7:0] CMSIR_RST_CONTROL = 8'h08;
   localparam logic [11:0] CMSIR_RST_THRESHOLD = 12'h570;
   localparam logic [1:0] CMSIR_RESP_OKAY = 2'h0;
   localparam logic [1:0] CMSIR_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {CMSIR_S_IDLE, CMSIR_S_RUN} cmsir_conv_t;
endpackage

// *** cmsir_host.sv ***
// Purpose: host side model, an axi4-lite master issuing single register accesses
// Assumes: one write or one read in flight, slave answers in its own time
// Notes: bench watchdog is the only limit on any wait
`timescale 1ns/1ps
module cmsir_host
   import cmsir_pkg::*;
(
   input wire logic aclk,
   output logic [31:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [31:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // ==========================================================
   // idle levels
   initial begin
      awaddr = 32'h0;
      wdata = 32'h0;
      araddr = 32'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
   end
   // ==========================================================
   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awaddr <= {22'h0, idx, 2'h0};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a && w)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask
   // ==========================================================
   // read: rready held until the data beat is sampled
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= {22'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

// *** cmsir_regs_tb.sv ***
// Purpose: self-checking bench for the cell monitor status and interrupt registers
// Assumes: event sources pulse for one cycle, sample index fixed at cell 2
// Notes: expectations come from package constants and literals, never from the design
`timescale 1ns/1ps
module cmsir_regs_tb
   import cmsir_pkg::*;
();
   logic aclk, aresetn, ftest, bv, rv, aw_v, w_v, ar_v, aw_r, w_r, ar_r, br, rr;
   logic [31:0] awa, wd, ara, rd;
   logic [1:0] bresp, rresp;
   logic [4:0] ev;
   logic [2:0] sidx;
   logic [11:0] sval;
   logic [11:0] thr;
   logic restart, tmr_en, irq, cstart, cabort;
   logic [5:0] bal;
   int miscompares = 0;
   int n_compared = 0;
   int nrst = 0;
   int nstart = 0;
   int nabort = 0;
   cmsir_regs u_cmsir_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(rd), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .conversion_finished(ev[0]),
      .slow_timer_elapsed(ev[1]), .bad_frame_length(ev[2]), .checksum_fault(ev[4]),
      .factory_test_active(ftest), .cell_sample_valid(ev[3]), .cell_sample_index(sidx),
      .cell_sample_value(sval), .conversion_start(cstart), .conversion_abort(cabort),
      .slow_timer_restart(restart), .slow_timer_enable(tmr_en), .low_cell_threshold(thr),
      .cell_balance_enable(bal), .irq(irq));
   cmsir_host u_cmsir_host (.aclk(aclk), .awaddr(awa), .awvalid(aw_v), .awready(aw_r),
      .wdata(wd), .wvalid(w_v), .wready(w_r), .bresp(bresp), .bvalid(bv), .bready(br),
      .araddr(ara), .arvalid(ar_v), .arready(ar_r), .rdata(rd), .rresp(rresp),
      .rvalid(rv), .rready(rr));
   // ==========================================================
   // clock and restart, start and abort pulse counters
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) if (restart === 1'b1) nrst++;
   always @(posedge aclk) if (cstart === 1'b1) nstart++;
   always @(posedge aclk) if (cabort === 1'b1) nabort++;
   // ==========================================================
   // checking helpers
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [1:0] r;
      u_cmsir_host.wr(idx, d, r);
      chk("bresp", {30'h0, r}, {30'h0, CMSIR_RESP_OKAY});
   endtask
   task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp,
                      input logic [31:0] msk = 32'hffffffff);
      logic [31:0] d;
      logic [1:0] r;
      u_cmsir_host.rd(idx, d, r);
      chk(nm, d & msk, exp);
   endtask
   // one-cycle event pulse, then time for flag and irq to settle
   task automatic pulse(input int i);
      @(posedge aclk);
      ev <= 5'h1 << i;
      @(posedge aclk);
      ev <= 5'h0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic close_out();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      close_out();
   end
   // ==========================================================
   // tests
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      aresetn = 1'b0;
      ev = 5'h0;
      ftest = 1'b0;
      sidx = 3'h2;
      sval = 12'h100;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("irq", {31'h0, irq}, 32'h0);
      chk("timer_en", {31'h0, tmr_en}, 32'h1);
      chk("threshold", {20'h0, thr}, {20'h0, CMSIR_RST_THRESHOLD});
      rdc("flags", CMSIR_IDX_FLAGS, 32'h20);
      rdc("flags", CMSIR_IDX_FLAGS, 32'h0);
      rdc("mask", CMSIR_IDX_MASK, 32'h0);
      rdc("cell_low", CMSIR_IDX_CELL_LOW, 32'h0);
      rdc("balance", CMSIR_IDX_BALANCE, 32'h0);
      u_cmsir_host.rd(8'h07, d, r);
      chk("rresp", {30'h0, r}, {30'h0, CMSIR_RESP_SLVERR});
      // all six balance enables at once, then a sparse pattern
      wr(CMSIR_IDX_BALANCE, 32'h3f);
      chk("bal_out", {26'h0, bal}, 32'h3f);
      rdc("balance", CMSIR_IDX_BALANCE, 32'h3f);
      wr(CMSIR_IDX_BALANCE, 32'h15);
      chk("bal_out", {26'h0, bal}, 32'h15);
      // start, restart without reading progress, abort
      wr(CMSIR_IDX_OPERATION, 32'h1);
      rdc("progress", CMSIR_IDX_PROGRESS, {30'h0, CMSIR_PROG_RUN});
      rdc("progress", CMSIR_IDX_PROGRESS, {30'h0, CMSIR_PROG_RUN});
      wr(CMSIR_IDX_OPERATION, 32'h0);
      wr(CMSIR_IDX_OPERATION, 32'h1);
      rdc("progress", CMSIR_IDX_PROGRESS, {30'h0, CMSIR_PROG_RUN});
      wr(CMSIR_IDX_OPERATION, 32'h0);
      rdc("progress", CMSIR_IDX_PROGRESS, {30'h0, CMSIR_PROG_CANCEL});
      rdc("progress", CMSIR_IDX_PROGRESS, 32'h0);
      // every event source, unmasked then masked
      for (int i = 0; i < 5; i++) begin
         for (int m = 0; m < 2; m++) begin
            if (i == 0) wr(CMSIR_IDX_OPERATION, 32'h1);
            wr(CMSIR_IDX_MASK, (m == 1) ? (32'h1 << i) : 32'h0);
            pulse(i);
            chk("irq", {31'h0, irq}, (m == 1) ? 32'h0 : 32'h1);
            rdc("flags", CMSIR_IDX_FLAGS, 32'h1 << i);
            repeat (2) @(posedge aclk);
            chk("irq", {31'h0, irq}, 32'h0);
            if (i == 0) begin
               rdc("op_req", CMSIR_IDX_OPERATION, 32'h0, 32'h1);
               rdc("progress", CMSIR_IDX_PROGRESS, {30'h0, CMSIR_PROG_DONE});
               rdc("progress", CMSIR_IDX_PROGRESS, 32'h0);
            end
         end
      end
      wr(CMSIR_IDX_MASK, 32'h0);
      rdc("cell_low", CMSIR_IDX_CELL_LOW, 32'h4);
      // test mode level shows in flags but stays quiet on irq
      ftest <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("irq", {31'h0, irq}, 32'h0);
      rdc("flags", CMSIR_IDX_FLAGS, 32'h40, 32'h40);
      ftest <= 1'b0;
      // timer restart only on a 1 and only while enabled
      wr(CMSIR_IDX_SOFT_RESET, 32'h2);
      repeat (2) @(posedge aclk);
      chk("restarts", nrst, 32'h1);
      wr(CMSIR_IDX_SOFT_RESET, 32'h0);
      wr(CMSIR_IDX_CONTROL, 32'h0);
      // enable output follows the control bit one cycle later
      @(posedge aclk);
      chk("timer_en", {31'h0, tmr_en}, 32'h0);
      wr(CMSIR_IDX_SOFT_RESET, 32'h2);
      repeat (2) @(posedge aclk);
      chk("restarts", nrst, 32'h1);
      chk("starts", nstart, 32'h4);
      chk("aborts", nabort, 32'h2);
      close_out();
   end
endmodule
